// ---- hdl/lctr_regs.v ----
// How it works
// RULE1: Host clears heaters at cutoff temperature.
// RULE2: Cutoff register is unsigned eight-bit Celsius.
// RULE3: Three independent heater spot drive outputs.
// RULE4: Set command applies power limit to spots.
// RULE5: Bit n set disables network lane n.
// RULE6: Transmit bit 14 enables pattern generator.
// RULE7: Two-bit field selects pattern length.
// RULE8: FIFO reset bits drive both transmit FIFOs.
// RULE9: Bit 8 resets its transmit or receive path.
// RULE10: Monitor clock field decodes divider and source.
// RULE11: Rate field selects one of four rates.
// RULE12: Bit 0 selects reference ratio sixteen/sixty-four.
// RULE13: Both network control registers reset to 0200h.
// RULE14: Receive bit 15 activates decision voltage function.
// RULE15: Receive bit 14 enables pattern checker.
// RULE16: Receive bit 11 locks monitor clock.
// RULE17: Receive bit 10 enables network loopback.
// RULE18: Receive auto FIFO reset, forced FIFO reset.
// RULE19: Host bit 14 enables host checker.
// RULE20: Host bit 10 enables host loopback.
// RULE21: Host bit 7 enables host generator.
// RULE22: Reserved bits read zero, ignore writes.
// RULE23: Soft reset self-clears, ORs pin, ignores zero.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`include "lctr_consts.vh"
module lctr_regs #(
  parameter AW = 18
) (
  // Clock, reset, enable
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          clk_en,
  // Pins
  input  wire          module_reset_pin_n,
  // AXI4-Lite write
  input  wire [AW-1:0] s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  // AXI4-Lite read
  input  wire [AW-1:0] s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  // Lane controls
  output reg  [15:0]   lane_transmit_disable,
  output reg           tx_prbs_gen_en,
  output reg  [1:0]    tx_prbs_pattern,
  output reg           tx_deskew_disable,
  output reg           tx_fifo_reset_host,
  output reg           tx_fifo_reset_net,
  output reg           tx_fifo_auto_host,
  output reg           tx_fifo_auto_net,
  output reg           tx_path_reset,
  output reg           tx_mclk_en,
  output reg           tx_mclk_host_src,
  output reg  [6:0]    tx_mclk_div,
  output reg  [1:0]    tx_rate_sel,
  output reg           tx_refclk_div64,
  output reg           rx_advp_active,
  output reg           rx_prbs_chk_en,
  output reg  [1:0]    rx_prbs_pattern,
  output reg           rx_mclk_lock_ref,
  output reg           net_loopback_en,
  output reg           rx_fifo_auto,
  output reg           rx_path_reset,
  output reg           rx_mclk_en,
  output reg           rx_mclk_host_src,
  output reg  [6:0]    rx_mclk_div,
  output reg           rx_fifo_reset,
  output reg  [1:0]    rx_rate_sel,
  output reg           rx_refclk_div64,
  output reg           host_prbs_chk_en,
  output reg  [1:0]    host_chk_pattern,
  output reg           host_loopback_en,
  output reg           host_prbs_gen_en,
  output reg  [1:0]    host_gen_pattern,
  // Thermal, power and module reset
  output reg  [7:0]    cutoff_temp,
  output reg  [7:0]    spot_drive_1,
  output reg  [7:0]    spot_drive_2,
  output reg  [7:0]    spot_drive_3,
  output reg           module_reset
);

  reg [15:0] network_transmit_control;
  reg [15:0] network_receive_control;
  reg [15:0] per_lane_transmit_disable;
  reg [15:0] host_lane_control;
  reg [7:0]  thermal_cutoff_temperature;
  reg [7:0]  max_power;
  reg [7:0]  spot_value_1;
  reg [7:0]  spot_value_2;
  reg [7:0]  spot_value_3;
  reg [3:0]  softrst_cnt;
  reg        pin_meta;
  reg        pin_sync;
  reg        aw_held;
  reg        w_held;
  reg [AW-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [15:0] rd_word;
  reg        rd_hit;
  reg        wr_hit;
  reg [15:0] wr_idx;
  reg [15:0] rd_idx;
  reg [15:0] wmask;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire do_read  = s_axi_arvalid && s_axi_arready;

  // Byte lanes 2 and 3 fall above the 16-bit registers and are ignored.
  always @* begin
    wmask  = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wr_idx = aw_addr[AW-1:2];
    rd_idx = s_axi_araddr[AW-1:2];
    wr_hit = (wr_idx == `LCTR_IDX_CUTOFF) || (wr_idx == `LCTR_IDX_NTX) ||
             (wr_idx == `LCTR_IDX_NRX) || (wr_idx == `LCTR_IDX_LANEDIS) ||
             (wr_idx == `LCTR_IDX_HOST) || (wr_idx == `LCTR_IDX_POWER) ||
             (wr_idx == `LCTR_IDX_SPOT1) || (wr_idx == `LCTR_IDX_SPOT2) ||
             (wr_idx == `LCTR_IDX_SPOT3) || (wr_idx == `LCTR_IDX_SOFTRST);
    rd_hit = 1'b1;
    rd_word = `LCTR_RST_ZERO16;
    case (rd_idx)
      `LCTR_IDX_CUTOFF:  rd_word = {8'h00, thermal_cutoff_temperature}; // [RULE2]
      `LCTR_IDX_NTX:     rd_word = network_transmit_control;
      `LCTR_IDX_NRX:     rd_word = network_receive_control;
      `LCTR_IDX_LANEDIS: rd_word = per_lane_transmit_disable;
      `LCTR_IDX_HOST:    rd_word = host_lane_control;
      `LCTR_IDX_POWER:   rd_word = {8'h00, max_power};
      `LCTR_IDX_SPOT1:   rd_word = {8'h00, spot_drive_1};
      `LCTR_IDX_SPOT2:   rd_word = {8'h00, spot_drive_2};
      `LCTR_IDX_SPOT3:   rd_word = {8'h00, spot_drive_3};
      `LCTR_IDX_SOFTRST: rd_word = {module_reset, 15'h0000};
      default:           rd_hit = 1'b0;
    endcase
  end

  // Caps one spot value at the programmed power limit.
  function [7:0] lctr_cap;
    input [7:0] val;
    input [7:0] lim;
    begin
      lctr_cap = (val > lim) ? lim : val;
    end
  endfunction

  // Pin synchroniser.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b1;
      pin_sync <= 1'b1;
    end else if (clk_en) begin
      pin_meta <= module_reset_pin_n;
      pin_sync <= pin_meta;
    end
  end

  // AXI4-Lite slave: write address and data accepted in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `LCTR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `LCTR_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {AW{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `LCTR_RESP_OKAY : `LCTR_RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_word};
        s_axi_rresp  <= rd_hit ? `LCTR_RESP_OKAY : `LCTR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register file.
  always @(posedge aclk) begin
    if (!aresetn) begin
      network_transmit_control   <= `LCTR_RST_NTX; // [RULE13]
      network_receive_control    <= `LCTR_RST_NRX; // [RULE13]
      per_lane_transmit_disable  <= `LCTR_RST_ZERO16;
      host_lane_control          <= `LCTR_RST_ZERO16;
      thermal_cutoff_temperature <= `LCTR_RST_CUTOFF;
      max_power                  <= `LCTR_RST_POWER;
      spot_value_1               <= 8'h00;
      spot_value_2               <= 8'h00;
      spot_value_3               <= 8'h00;
      softrst_cnt                <= 4'h0;
    end else if (clk_en) begin
      if (softrst_cnt != 4'h0) begin
        softrst_cnt <= softrst_cnt - 4'h1; // [RULE23]
      end
      if (do_write) begin
        case (wr_idx)
          `LCTR_IDX_NTX:
            network_transmit_control <= (network_transmit_control & ~(wmask &
              `LCTR_MASK_NTX)) | (w_data[15:0] & wmask & `LCTR_MASK_NTX); // [RULE22]
          `LCTR_IDX_NRX:
            network_receive_control <= (network_receive_control & ~wmask) |
              (w_data[15:0] & wmask & `LCTR_MASK_NRX);
          `LCTR_IDX_LANEDIS:
            per_lane_transmit_disable <= (per_lane_transmit_disable & ~wmask) |
              (w_data[15:0] & wmask);
          `LCTR_IDX_HOST:
            host_lane_control <= (host_lane_control & ~(wmask & `LCTR_MASK_HOST)) |
              (w_data[15:0] & wmask & `LCTR_MASK_HOST); // [RULE22]
          `LCTR_IDX_CUTOFF:
            if (w_strb[0]) thermal_cutoff_temperature <= w_data[7:0]; // [RULE2]
          `LCTR_IDX_POWER:
            if (w_strb[0]) begin
              max_power <= w_data[7:0]; // [RULE4]
            end
          `LCTR_IDX_SPOT1:
            if (w_strb[0]) spot_value_1 <= w_data[7:0]; // [RULE3]
          `LCTR_IDX_SPOT2:
            if (w_strb[0]) spot_value_2 <= w_data[7:0]; // [RULE3]
          `LCTR_IDX_SPOT3:
            if (w_strb[0]) spot_value_3 <= w_data[7:0]; // [RULE3]
          `LCTR_IDX_SOFTRST:
            if (w_strb[1] && w_data[`LCTR_BIT_SOFTRST]) begin
              softrst_cnt <= `LCTR_SOFTRST_CYC; // [RULE23]
            end
          default: begin
          end
        endcase
      end
    end
  end

  // Output decode. The host cools the module by writing zero spots itself.
  always @(posedge aclk) begin
    if (!aresetn) begin
      lane_transmit_disable <= 16'h0000;
      tx_prbs_gen_en     <= 1'b0;
      tx_prbs_pattern    <= 2'h0;
      tx_deskew_disable  <= 1'b0;
      tx_fifo_reset_host <= 1'b0;
      tx_fifo_reset_net  <= 1'b0;
      tx_fifo_auto_host  <= 1'b1;
      tx_fifo_auto_net   <= 1'b1;
      tx_path_reset      <= 1'b0;
      tx_mclk_en         <= 1'b0;
      tx_mclk_host_src   <= 1'b0;
      tx_mclk_div        <= 7'h00;
      tx_rate_sel        <= 2'h0;
      tx_refclk_div64    <= 1'b0;
      rx_advp_active     <= 1'b0;
      rx_prbs_chk_en     <= 1'b0;
      rx_prbs_pattern    <= 2'h0;
      rx_mclk_lock_ref   <= 1'b0;
      net_loopback_en    <= 1'b0;
      rx_fifo_auto       <= 1'b1;
      rx_path_reset      <= 1'b0;
      rx_mclk_en         <= 1'b0;
      rx_mclk_host_src   <= 1'b0;
      rx_mclk_div        <= 7'h00;
      rx_fifo_reset      <= 1'b0;
      rx_rate_sel        <= 2'h0;
      rx_refclk_div64    <= 1'b0;
      host_prbs_chk_en   <= 1'b0;
      host_chk_pattern   <= 2'h0;
      host_loopback_en   <= 1'b0;
      host_prbs_gen_en   <= 1'b0;
      host_gen_pattern   <= 2'h0;
      cutoff_temp        <= `LCTR_RST_CUTOFF;
      spot_drive_1       <= 8'h00;
      spot_drive_2       <= 8'h00;
      spot_drive_3       <= 8'h00;
      module_reset       <= 1'b1;
    end else if (clk_en) begin
      lane_transmit_disable <= per_lane_transmit_disable; // [RULE5]
      tx_prbs_gen_en     <= network_transmit_control[`LCTR_BIT_PRBS]; // [RULE6]
      tx_prbs_pattern    <= network_transmit_control[`LCTR_BIT_PAT_HI:`LCTR_BIT_PAT_LO]; // [RULE7]
      tx_deskew_disable  <= network_transmit_control[`LCTR_BIT_DESKEW];
      tx_fifo_reset_host <= network_transmit_control[`LCTR_BIT_FIFO_RST]; // [RULE8]
      tx_fifo_reset_net  <= network_transmit_control[`LCTR_BIT_FIFO_RST]; // [RULE8]
      tx_fifo_auto_host  <= network_transmit_control[`LCTR_BIT_FIFO_AUTO]; // [RULE8]
      tx_fifo_auto_net   <= network_transmit_control[`LCTR_BIT_FIFO_AUTO]; // [RULE8]
      tx_path_reset      <= network_transmit_control[`LCTR_BIT_PATH_RST]; // [RULE9]
      {tx_mclk_en, tx_mclk_host_src, tx_mclk_div} <=
        mclk_dec(network_transmit_control[`LCTR_BIT_MCLK_HI:`LCTR_BIT_MCLK_LO]); // [RULE10]
      tx_rate_sel        <= rate_dec(network_transmit_control[`LCTR_BIT_RATE_HI:`LCTR_BIT_RATE_LO]); // [RULE11]
      tx_refclk_div64    <= network_transmit_control[`LCTR_BIT_REFCLK]; // [RULE12]
      rx_advp_active     <= network_receive_control[`LCTR_BIT_ADVP]; // [RULE14]
      rx_prbs_chk_en     <= network_receive_control[`LCTR_BIT_PRBS]; // [RULE15]
      rx_prbs_pattern    <= network_receive_control[`LCTR_BIT_PAT_HI:`LCTR_BIT_PAT_LO]; // [RULE7]
      rx_mclk_lock_ref   <= network_receive_control[`LCTR_BIT_LOCK]; // [RULE16]
      net_loopback_en    <= network_receive_control[`LCTR_BIT_LOOP]; // [RULE17]
      rx_fifo_auto       <= network_receive_control[`LCTR_BIT_FIFO_AUTO]; // [RULE18]
      rx_path_reset      <= network_receive_control[`LCTR_BIT_PATH_RST]; // [RULE9]
      {rx_mclk_en, rx_mclk_host_src, rx_mclk_div} <=
        mclk_dec(network_receive_control[`LCTR_BIT_MCLK_HI:`LCTR_BIT_MCLK_LO]); // [RULE10]
      rx_fifo_reset      <= network_receive_control[`LCTR_BIT_RXFIFO_RST]; // [RULE18]
      rx_rate_sel        <= rate_dec(network_receive_control[`LCTR_BIT_RATE_HI:`LCTR_BIT_RATE_LO]); // [RULE11]
      rx_refclk_div64    <= network_receive_control[`LCTR_BIT_REFCLK]; // [RULE12]
      host_prbs_chk_en   <= host_lane_control[`LCTR_BIT_PRBS]; // [RULE19]
      host_chk_pattern   <= host_lane_control[`LCTR_BIT_PAT_HI:`LCTR_BIT_PAT_LO]; // [RULE19]
      host_loopback_en   <= host_lane_control[`LCTR_BIT_LOOP]; // [RULE20]
      host_prbs_gen_en   <= host_lane_control[`LCTR_BIT_HGEN]; // [RULE21]
      host_gen_pattern   <= host_lane_control[`LCTR_BIT_HPAT_HI:`LCTR_BIT_HPAT_LO]; // [RULE21]
      cutoff_temp        <= thermal_cutoff_temperature;
      // Spots follow the limit continuously, so a lowered limit bites at once.
      spot_drive_1       <= lctr_cap(spot_value_1, max_power); // [RULE4]
      spot_drive_2       <= lctr_cap(spot_value_2, max_power); // [RULE4]
      spot_drive_3       <= lctr_cap(spot_value_3, max_power); // [RULE4]
      module_reset       <= !pin_sync || (softrst_cnt != 4'h0); // [RULE23]
    end
  end

  // Monitor clock: {enable, host source, divider}; reserved codes stay disabled.
  function [8:0] mclk_dec;
    input [2:0] code;
    begin
      case (code)
        3'h2:    mclk_dec = {1'b1, 1'b0, 7'h08};
        3'h4:    mclk_dec = {1'b1, 1'b0, 7'h40};
        3'h5:    mclk_dec = {1'b1, 1'b1, 7'h40};
        3'h6:    mclk_dec = {1'b1, 1'b0, 7'h10};
        3'h7:    mclk_dec = {1'b1, 1'b1, 7'h10};
        default: mclk_dec = {1'b0, 1'b0, 7'h00};
      endcase
    end
  endfunction

  // Reserved rate codes fall back to the Ethernet rate.
  function [1:0] rate_dec;
    input [2:0] code;
    begin
      rate_dec = code[2] ? 2'h0 : code[1:0];
    end
  endfunction

endmodule

// ---- pkg/lctr_consts.vh ----
`ifndef LCTR_CONSTS_VH
`define LCTR_CONSTS_VH
`define LCTR_IDX_CUTOFF     16'h8800
`define LCTR_IDX_NTX        16'hA011
`define LCTR_IDX_NRX        16'hA012
`define LCTR_IDX_LANEDIS    16'hA013
`define LCTR_IDX_HOST       16'hA014
`define LCTR_IDX_POWER      16'hA015
`define LCTR_IDX_SPOT1      16'hA016
`define LCTR_IDX_SPOT2      16'hA017
`define LCTR_IDX_SPOT3      16'hA018
`define LCTR_IDX_SOFTRST    16'hA010
`define LCTR_RST_NTX        16'h0200
`define LCTR_RST_NRX        16'h0200
`define LCTR_RST_ZERO16     16'h0000
`define LCTR_RST_CUTOFF     8'hFF
`define LCTR_RST_POWER      8'h00
`define LCTR_MASK_NTX       16'h7FEF
`define LCTR_MASK_NRX       16'hFFFF
`define LCTR_MASK_HOST      16'h74E0
`define LCTR_BIT_SOFTRST    15
`define LCTR_BIT_PRBS       14
`define LCTR_BIT_PAT_HI     13
`define LCTR_BIT_PAT_LO     12
`define LCTR_BIT_DESKEW     11
`define LCTR_BIT_LOCK       11
`define LCTR_BIT_LOOP       10
`define LCTR_BIT_FIFO_RST   10
`define LCTR_BIT_FIFO_AUTO  9
`define LCTR_BIT_PATH_RST   8
`define LCTR_BIT_MCLK_HI    7
`define LCTR_BIT_MCLK_LO    5
`define LCTR_BIT_RXFIFO_RST 4
`define LCTR_BIT_RATE_HI    3
`define LCTR_BIT_RATE_LO    1
`define LCTR_BIT_REFCLK     0
`define LCTR_BIT_ADVP       15
`define LCTR_BIT_HGEN       7
`define LCTR_BIT_HPAT_HI    6
`define LCTR_BIT_HPAT_LO    5
`define LCTR_RESP_OKAY      2'h0
`define LCTR_RESP_SLVERR    2'h2
`define LCTR_SOFTRST_CYC    4'h8
`endif

// ---- dv/lctr_regs_chk.sv ----
`timescale 1ns/1ps
module lctr_regs_chk (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus answers
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  // Decoded controls
  input wire        tx_fifo_reset_host,
  input wire        tx_fifo_reset_net,
  input wire        tx_fifo_auto_host,
  input wire        tx_fifo_auto_net,
  input wire        rx_fifo_auto,
  input wire        tx_mclk_en,
  input wire        tx_mclk_host_src,
  input wire [6:0]  tx_mclk_div,
  input wire [7:0]  cutoff_temp,
  // Module reset
  input wire        module_reset_pin_n,
  input wire        module_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // The pin crosses a two-stage synchroniser, so four low samples are allowed for.
  sequence pin_held;
    !module_reset_pin_n [*4];
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_pin_reset: assert property (pin_held |-> module_reset)
    else $error("module reset did not follow the pin");
  chk_fifo_rst_pair: assert property (tx_fifo_reset_host == tx_fifo_reset_net)
    else $error("transmit FIFO resets differ");
  chk_fifo_auto_pair: assert property (tx_fifo_auto_host == tx_fifo_auto_net)
    else $error("transmit FIFO auto resets differ");
  chk_reset_values: assert property (!$past(aresetn) |->
    tx_fifo_auto_host && rx_fifo_auto && cutoff_temp == 8'hFF)
    else $error("control outputs wrong after reset");
  chk_mclk_legal: assert property (tx_mclk_en |-> tx_mclk_div == 7'h10 ||
    tx_mclk_div == 7'h40 || (tx_mclk_div == 7'h08 && !tx_mclk_host_src))
    else $error("monitor clock divider illegal");
  chk_mclk_off: assert property (!tx_mclk_en |-> tx_mclk_div == 7'h00)
    else $error("monitor clock divider set while disabled");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before accepted");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before accepted");
  chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind lctr_regs lctr_regs_chk u_lctr_regs_chk (.*);

// ---- dv/lctr_host_model.sv ----
`timescale 1ns/1ps
`include "lctr_consts.vh"
module lctr_host_model (
  // Clock
  input  wire        aclk,
  // Write channels
  output reg  [17:0] awaddr  = 18'h00000,
  output reg         awvalid = 1'b0,
  input  wire        awready,
  output reg  [31:0] wdata   = 32'h00000000,
  output reg         wvalid  = 1'b0,
  input  wire        wready,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output reg         bready  = 1'b0,
  // Read channels
  output reg  [17:0] araddr  = 18'h00000,
  output reg         arvalid = 1'b0,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output reg         rready  = 1'b0
);
  // A slow host raises its ready only after it has seen the answer.
  reg slow = 1'b0;
  task wr(input [15:0] idx, input [31:0] d, output [1:0] resp);
    begin
      awaddr <= {idx, 2'h0};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !slow;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) bready <= 1'b1;
      end while (awvalid || wvalid || !(bvalid && bready));
      resp = bresp;
      bready <= 1'b0;
      // An idle edge keeps back-to-back calls from driving ready twice in one step.
      @(posedge aclk);
    end
  endtask
  task rd(input [15:0] idx, output [31:0] d, output [1:0] resp);
    begin
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= !slow;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) rready <= 1'b1;
      end while (arvalid || !(rvalid && rready));
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task thermal_guard(input [7:0] temp);
    reg [31:0] d;
    reg [1:0]  r;
    begin
      rd(`LCTR_IDX_CUTOFF, d, r);
      if (temp >= d[7:0]) begin
        wr(`LCTR_IDX_SPOT1, 32'h0, r);
        wr(`LCTR_IDX_SPOT2, 32'h0, r);
        wr(`LCTR_IDX_SPOT3, 32'h0, r);
        wr(`LCTR_IDX_POWER, 32'h0, r);
      end
    end
  endtask
endmodule

// ---- dv/lane_control_and_thermal_regs_bench.sv ----
`timescale 1ns/1ps
`include "lctr_consts.vh"
module lane_control_and_thermal_regs_bench;
  reg         aclk               = 1'b0;
  reg         aresetn            = 1'b0;
  reg         module_reset_pin_n = 1'b1;
  integer     n_fail             = 0;
  integer     check_count        = 0;
  integer     i;
  integer     k;
  reg  [31:0] m;
  wire [17:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [1:0]  s_axi_bresp, s_axi_rresp, tx_prbs_pattern, tx_rate_sel, rx_prbs_pattern;
  wire [1:0]  rx_rate_sel, host_chk_pattern, host_gen_pattern;
  wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [15:0] lane_transmit_disable;
  wire [6:0]  tx_mclk_div, rx_mclk_div;
  wire [7:0]  cutoff_temp, spot_drive_1, spot_drive_2, spot_drive_3;
  wire        tx_prbs_gen_en, tx_deskew_disable, tx_fifo_reset_host, tx_fifo_reset_net;
  wire        tx_fifo_auto_host, tx_fifo_auto_net, tx_path_reset, tx_mclk_en, tx_mclk_host_src;
  wire        tx_refclk_div64, rx_advp_active, rx_prbs_chk_en, rx_mclk_lock_ref;
  wire        net_loopback_en, rx_fifo_auto, rx_path_reset, rx_mclk_en, rx_mclk_host_src;
  wire        rx_fifo_reset, rx_refclk_div64, host_prbs_chk_en, host_loopback_en;
  wire        host_prbs_gen_en, module_reset;
  always #12.5 aclk = ~aclk;
  lctr_regs #(.AW(18)) u_lctr_regs (.clk_en(1'b1), .s_axi_wstrb(4'hF), .*);
  lctr_host_model u_lctr_host_model (
    .aclk, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid), .awready(s_axi_awready),
    .wdata(s_axi_wdata), .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
    .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wreg(input [15:0] idx, input [31:0] d, input [1:0] er);
    reg [1:0] r;
    begin
      u_lctr_host_model.wr(idx, d, r);
      chk($sformatf("bresp %h", idx), {30'h0, er}, {30'h0, r});
    end
  endtask
  task rreg(input [15:0] idx, input [31:0] ed, input [1:0] er);
    reg [31:0] d;
    reg [1:0]  r;
    begin
      u_lctr_host_model.rd(idx, d, r);
      chk($sformatf("rdata %h", idx), ed, d);
      chk($sformatf("rresp %h", idx), {30'h0, er}, {30'h0, r});
    end
  endtask
  function [8:0] mclk_exp(input [2:0] c);
    case (c)
      3'h2: mclk_exp = {2'h2, 7'h08};
      3'h4: mclk_exp = {2'h2, 7'h40};
      3'h5: mclk_exp = {2'h3, 7'h40};
      3'h6: mclk_exp = {2'h2, 7'h10};
      3'h7: mclk_exp = {2'h3, 7'h10};
      default: mclk_exp = 9'h000;
    endcase
  endfunction
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail = n_fail + 1;
    end_sim;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rreg(`LCTR_IDX_NTX, 32'h0200, `LCTR_RESP_OKAY);
    rreg(`LCTR_IDX_NRX, 32'h0200, `LCTR_RESP_OKAY);
    rreg(`LCTR_IDX_HOST, 32'h0, `LCTR_RESP_OKAY);
    chk("fifo auto", 3'h7, {tx_fifo_auto_host, tx_fifo_auto_net, rx_fifo_auto});
    for (k = 0; k < 2; k = k + 1) begin
      m = k ? 32'h0 : 32'hFFFFFFFF;
      wreg(`LCTR_IDX_NTX, m, `LCTR_RESP_OKAY);
      wreg(`LCTR_IDX_NRX, m, `LCTR_RESP_OKAY);
      wreg(`LCTR_IDX_HOST, m, `LCTR_RESP_OKAY);
      rreg(`LCTR_IDX_NTX, m & 32'h7FEF, `LCTR_RESP_OKAY);
      rreg(`LCTR_IDX_NRX, m & 32'hFFFF, `LCTR_RESP_OKAY);
      rreg(`LCTR_IDX_HOST, m & 32'h74E0, `LCTR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("tx controls", m & 32'h7F, {tx_prbs_gen_en, tx_deskew_disable, tx_fifo_reset_host,
        tx_fifo_reset_net, tx_fifo_auto_host, tx_fifo_auto_net, tx_path_reset});
      chk("rx controls", m & 32'h7F, {rx_advp_active, rx_prbs_chk_en, rx_mclk_lock_ref,
        net_loopback_en, rx_fifo_auto, rx_path_reset, rx_fifo_reset});
      chk("host controls", m & 32'h7F, {host_prbs_chk_en, host_chk_pattern, host_loopback_en,
        host_prbs_gen_en, host_gen_pattern});
    end
    for (i = 0; i < 8; i = i + 1) begin
      m = {18'h0, i[1:0], 4'h0, i[2:0], 1'b0, i[2:0], i[0]};
      wreg(`LCTR_IDX_NTX, m, `LCTR_RESP_OKAY);
      wreg(`LCTR_IDX_NRX, m, `LCTR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      m = {18'h0, mclk_exp(i[2:0]), (i < 4) ? i[1:0] : 2'h0, i[1:0], i[0]};
      chk("tx decode", m, {tx_mclk_en, tx_mclk_host_src, tx_mclk_div, tx_rate_sel,
        tx_prbs_pattern, tx_refclk_div64});
      chk("rx decode", m, {rx_mclk_en, rx_mclk_host_src, rx_mclk_div, rx_rate_sel,
        rx_prbs_pattern, rx_refclk_div64});
    end
    u_lctr_host_model.slow = 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      wreg(`LCTR_IDX_LANEDIS, 32'h1 << i, `LCTR_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("lane disable", 32'h1 << i, {16'h0, lane_transmit_disable});
    end
    rreg(`LCTR_IDX_LANEDIS, 32'h8000, `LCTR_RESP_OKAY);
    u_lctr_host_model.slow = 1'b0;
    wreg(`LCTR_IDX_CUTOFF, 32'hFFFFFFAB, `LCTR_RESP_OKAY);
    rreg(`LCTR_IDX_CUTOFF, 32'hAB, `LCTR_RESP_OKAY);
    chk("cutoff out", 32'hAB, {24'h0, cutoff_temp});
    wreg(`LCTR_IDX_POWER, 32'h40, `LCTR_RESP_OKAY);
    wreg(`LCTR_IDX_SPOT1, 32'h30, `LCTR_RESP_OKAY);
    wreg(`LCTR_IDX_SPOT2, 32'h50, `LCTR_RESP_OKAY);
    wreg(`LCTR_IDX_SPOT3, 32'hFF, `LCTR_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("spots", 32'h304040, {spot_drive_1, spot_drive_2, spot_drive_3});
    u_lctr_host_model.thermal_guard(8'hAB);
    repeat (2) @(posedge aclk);
    chk("spots", 32'h0, {spot_drive_1, spot_drive_2, spot_drive_3});
    wreg(16'h1234, 32'h5A5A, `LCTR_RESP_SLVERR);
    rreg(16'h1234, 32'h0, `LCTR_RESP_SLVERR);
    wreg(`LCTR_IDX_SOFTRST, 32'h0, `LCTR_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("module reset", 32'h0, {31'h0, module_reset});
    wreg(`LCTR_IDX_SOFTRST, 32'h8000, `LCTR_RESP_OKAY);
    chk("module reset", 32'h1, {31'h0, module_reset});
    repeat (16) @(posedge aclk);
    chk("module reset", 32'h0, {31'h0, module_reset});
    rreg(`LCTR_IDX_SOFTRST, 32'h0, `LCTR_RESP_OKAY);
    module_reset_pin_n <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("module reset", 32'h1, {31'h0, module_reset});
    module_reset_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("module reset", 32'h0, {31'h0, module_reset});
    end_sim;
  end
endmodule
